/* File: dmd_pkg.sv */
// shared constants, types and helpers for the descriptor decoder
package dmd_pkg;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_TABLE_BASE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CUR_DESC = 5'h0c;
  localparam logic [4:0] OFS_REMAIN = 5'h10;
  // control register fields
  localparam int CTL_INIT = 0;
  localparam int CTL_DESC_MODE = 1;
  localparam int CTL_DIR_LO = 2;
  localparam int CTL_SIZE_LO = 4;
  localparam int CTL_BCAST = 6;
  // control/status word fields
  localparam int DSC_CNT_LO = 16;
  localparam int DSC_RSV_LO = 6;
  localparam int DSC_BUF = 5;
  localparam int DSC_CONT = 4;
  localparam int DSC_CRC_KEEP = 3;
  localparam int DSC_IRQ = 2;
  localparam int DSC_ACT_LO = 0;
  // entry strides and word offsets
  localparam logic [31:0] STRIDE_DEV = 32'h0000_0008;
  localparam logic [31:0] STRIDE_M2M = 32'h0000_0010;
  localparam logic [31:0] OFF_START = 32'h0000_0000;
  localparam logic [31:0] OFF_CTRL_DEV = 32'h0000_0004;
  localparam logic [31:0] OFF_DST_M2M = 32'h0000_0008;
  localparam logic [31:0] OFF_CTRL_M2M = 32'h0000_000c;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [16:0] BYTES_1 = 17'h00001;
  localparam logic [16:0] BYTES_2 = 17'h00002;
  localparam logic [16:0] BYTES_4 = 17'h00004;

  typedef enum logic [1:0] {
    DIR_M2D = 2'b00,
    DIR_M2M = 2'b01,
    DIR_D2M = 2'b10,
    DIR_RSV = 2'b11
  } dmd_dir_e;

  typedef enum logic [1:0] {
    ACT_HALT = 2'b00,
    ACT_NEXT = 2'b01,
    ACT_RESTART = 2'b10,
    ACT_REPEAT = 2'b11
  } dmd_act_e;

  typedef enum logic [1:0] {
    SZ_8 = 2'b00,
    SZ_16 = 2'b01,
    SZ_32 = 2'b10,
    SZ_RSV = 2'b11
  } dmd_size_e;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] count;
    dmd_dir_e dir;
    dmd_size_e size;
  } dmd_xfer_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmd_mem_s;

  function automatic logic [16:0] item_bytes(input dmd_size_e sz);
    case (sz)
      SZ_16: item_bytes = BYTES_2;
      SZ_32: item_bytes = BYTES_4;
      default: item_bytes = BYTES_1;
    endcase
  endfunction
endpackage

/* File: dmd_byte_count.sv */
// byte counter for one descriptor transfer
`timescale 1ns/1ps
`default_nettype none
module dmd_byte_count
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_count,
  input wire logic beat,
  input wire dmd_size_e size,
  // state
  output logic [CNT_W:0] left,
  output logic [CNT_W-1:0] moved_m1,
  output logic terminal
);
  logic [CNT_W:0] moved;
  logic [CNT_W:0] step;

  assign step = item_bytes(size);

  // count held in bytes whatever the item width
  always_ff @(posedge clock) begin
    if (!nrst) begin
      left <= '0;
      moved <= '0;
    end else if (load) begin
      left <= {1'b0, load_count} + BYTES_1;
      moved <= '0;
    end else if (beat && left != '0) begin
      left <= (left > step) ? left - step : '0;
      moved <= moved + step;
    end
  end

  assign terminal = (left == '0);
  assign moved_m1 = (moved == '0) ? '0 : moved[CNT_W-1:0] - 16'h0001;
endmodule // dmd_byte_count
`default_nettype wire

/* File: dmd_mem_port.sv */
// single word read/write sequencer toward system memory
`timescale 1ns/1ps
`default_nettype none
module dmd_mem_port
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // command side
  input wire logic cmd_go,
  input wire logic cmd_we,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic busy,
  output logic done,
  output logic [31:0] rdata,
  // memory side
  output dmd_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mem <= '0;
      busy <= 1'b0;
    end else if (!busy && cmd_go) begin
      mem <= '{req: 1'b1, we: cmd_we, addr: cmd_addr, wdata: cmd_wdata};
      busy <= 1'b1;
    end else if (busy && mem_ack) begin
      mem.req <= 1'b0;
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      done <= 1'b0;
      rdata <= RESET_WORD;
    end else begin
      done <= busy && mem_ack;
      if (busy && mem_ack) begin
        rdata <= mem_rdata;
      end
    end
  end
endmodule // dmd_mem_port
`default_nettype wire

/* File: dmd_decoder.sv */
// descriptor fetch, check, sequencing and write-back for one channel
`timescale 1ns/1ps
`default_nettype none
module dmd_decoder
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // system memory
  output dmd_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // transfer engine and requests
  input wire logic dev_req,
  input wire logic xfer_beat,
  input wire logic xfer_last,
  output logic xfer_start,
  output dmd_xfer_s xfer_info,
  output logic crc_clear,
  // events
  input wire logic broadcast_in,
  output logic broadcast_out,
  output logic desc_irq,
  output logic busy
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_CHECK = 4'h2,
    ST_WAIT_BC = 4'h3,
    ST_WAIT_REQ = 4'h4,
    ST_RUN = 4'h5,
    ST_WBACK = 4'h6,
    ST_NEXT = 4'h7
  } dmd_state_e;

  dmd_state_e state;
  logic desc_mode;
  dmd_dir_e dir;
  dmd_size_e size;
  logic sw_init;
  logic sw_bcast;
  logic [31:0] descriptor_table_base;
  logic [31:0] cur_desc;
  logic [31:0] src_addr;
  logic [31:0] mem_addr;
  logic [31:0] ctrl_word;
  logic [1:0] widx;
  logic issued;
  logic req_pend;
  logic auto_go;
  logic mp_go;
  logic mp_we;
  logic [31:0] mp_addr;
  logic [31:0] mp_wdata;
  logic mp_busy;
  logic mp_done;
  logic [31:0] mp_rdata;
  logic cnt_load;
  logic [CNT_W:0] cnt_left;
  logic [CNT_W-1:0] cnt_moved_m1;
  logic cnt_terminal;
  logic is_m2m;
  logic last_word;
  logic buf_ok;
  logic bcast_any;
  logic go_now;
  logic [31:0] wb_word;

  // word offset inside an entry for each fetch step
  function automatic logic [31:0] word_off(input logic m2m, input logic [1:0] idx);
    case ({m2m, idx})
      3'b0_00: word_off = OFF_START;
      3'b0_01: word_off = OFF_CTRL_DEV;
      3'b1_00: word_off = OFF_START;
      3'b1_01: word_off = OFF_DST_M2M;
      3'b1_10: word_off = OFF_CTRL_M2M;
      default: word_off = OFF_START;
    endcase
  endfunction

  assign is_m2m = (dir == DIR_M2M);
  assign last_word = is_m2m ? (widx == 2'd2) : (widx == 2'd1);
  // device reads buffer in m2d, writes it in d2m
  assign buf_ok = is_m2m
      || (dir == DIR_M2D && ctrl_word[DSC_BUF])
      || (dir == DIR_D2M && !ctrl_word[DSC_BUF]);
  assign bcast_any = broadcast_in || sw_bcast;
  assign go_now = auto_go || req_pend;
  // count replaced, status replaced for device entries only, reserved and control bits kept
  assign wb_word = {cnt_moved_m1,
      ctrl_word[DSC_CNT_LO-1:DSC_RSV_LO],
      is_m2m ? ctrl_word[DSC_BUF] : (dir == DIR_D2M),
      ctrl_word[DSC_CONT:0]};

  // register writes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      desc_mode <= 1'b0;
      dir <= DIR_M2D;
      size <= SZ_8;
      descriptor_table_base <= RESET_WORD;
      sw_init <= 1'b0;
      sw_bcast <= 1'b0;
    end else begin
      sw_init <= 1'b0;
      sw_bcast <= 1'b0;
      if (reg_write && reg_addr == OFS_CONTROL) begin
        desc_mode <= reg_wdata[CTL_DESC_MODE];
        dir <= dmd_dir_e'(reg_wdata[CTL_DIR_LO +: 2]);
        size <= dmd_size_e'(reg_wdata[CTL_SIZE_LO +: 2]);
        sw_init <= reg_wdata[CTL_INIT];
        sw_bcast <= reg_wdata[CTL_BCAST];
      end
      if (reg_write && reg_addr == OFS_TABLE_BASE) begin
        descriptor_table_base <= reg_wdata;
      end
    end
  end

  // register reads, data only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= RESET_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        OFS_CONTROL: reg_rdata <= {25'h0, 1'b0, size, dir, desc_mode, 1'b0};
        OFS_TABLE_BASE: reg_rdata <= descriptor_table_base;
        OFS_STATUS: reg_rdata <= {21'h0, req_pend, auto_go, busy, 4'h0, state};
        OFS_CUR_DESC: reg_rdata <= cur_desc;
        OFS_REMAIN: reg_rdata <= {15'h0, cnt_left};
        default: reg_rdata <= RESET_WORD;
      endcase
    end else begin
      reg_rdata <= RESET_WORD;
    end
  end

  // pending request, a new request wins over its consumption
  always_ff @(posedge clock) begin
    if (!nrst) begin
      req_pend <= 1'b0;
    end else if (dev_req) begin
      req_pend <= 1'b1;
    end else if (sw_init || (state == ST_WAIT_REQ && go_now)) begin
      req_pend <= 1'b0;
    end
  end

  // main sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cur_desc <= RESET_WORD;
      src_addr <= RESET_WORD;
      mem_addr <= RESET_WORD;
      ctrl_word <= RESET_WORD;
      widx <= 2'd0;
      issued <= 1'b0;
      auto_go <= 1'b0;
      mp_go <= 1'b0;
      mp_we <= 1'b0;
      mp_addr <= RESET_WORD;
      mp_wdata <= RESET_WORD;
      cnt_load <= 1'b0;
    end else begin
      mp_go <= 1'b0;
      cnt_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (sw_init && desc_mode) begin
            cur_desc <= descriptor_table_base;
            auto_go <= 1'b0;
            widx <= 2'd0;
            issued <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!issued && !mp_busy) begin
            mp_go <= 1'b1;
            mp_we <= 1'b0;
            mp_addr <= cur_desc + word_off(is_m2m, widx);
            issued <= 1'b1;
          end else if (mp_done) begin
            issued <= 1'b0;
            widx <= widx + 2'd1;
            if (widx == 2'd0 && is_m2m) begin
              src_addr <= mp_rdata;
            end else if (!last_word) begin
              mem_addr <= mp_rdata;
            end else if (is_m2m) begin
              ctrl_word <= mp_rdata;
            end
            if (widx == 2'd0 && !is_m2m) begin
              mem_addr <= mp_rdata;
            end
            if (last_word) begin
              ctrl_word <= mp_rdata;
              state <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (buf_ok) begin
            cnt_load <= 1'b1;
            state <= ST_WAIT_REQ;
          end else begin
            state <= ST_WAIT_BC;
          end
        end
        ST_WAIT_BC: begin
          if (bcast_any) begin
            widx <= 2'd0;
            issued <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_WAIT_REQ: begin
          if (go_now) begin
            auto_go <= 1'b0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!xfer_start && (cnt_terminal || xfer_last)) begin
            mp_go <= 1'b1;
            mp_we <= 1'b1;
            mp_addr <= cur_desc + (is_m2m ? OFF_CTRL_M2M : OFF_CTRL_DEV);
            mp_wdata <= wb_word;
            issued <= 1'b1;
            state <= ST_WBACK;
          end
        end
        ST_WBACK: begin
          if (mp_done) begin
            issued <= 1'b0;
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          widx <= 2'd0;
          auto_go <= ctrl_word[DSC_CONT];
          case (dmd_act_e'(ctrl_word[DSC_ACT_LO +: 2]))
            ACT_HALT: state <= ST_IDLE;
            ACT_NEXT: begin
              cur_desc <= cur_desc + (is_m2m ? STRIDE_M2M : STRIDE_DEV);
              state <= ST_FETCH;
            end
            ACT_RESTART: begin
              cur_desc <= descriptor_table_base;
              state <= ST_FETCH;
            end
            default: state <= ST_FETCH;
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // transfer launch toward the data engine
  always_ff @(posedge clock) begin
    if (!nrst) begin
      xfer_start <= 1'b0;
      xfer_info <= '0;
      crc_clear <= 1'b0;
    end else begin
      xfer_start <= (state == ST_WAIT_REQ) && go_now;
      crc_clear <= (state == ST_WAIT_REQ) && go_now && desc_mode
          && !ctrl_word[DSC_CRC_KEEP];
      if (state == ST_WAIT_REQ && go_now) begin
        xfer_info.src <= is_m2m ? src_addr : RESET_WORD;
        xfer_info.dst <= mem_addr;
        xfer_info.count <= ctrl_word[31:DSC_CNT_LO];
        xfer_info.dir <= dir;
        xfer_info.size <= size;
      end
    end
  end

  // completion events
  always_ff @(posedge clock) begin
    if (!nrst) begin
      desc_irq <= 1'b0;
      broadcast_out <= 1'b0;
      busy <= 1'b0;
    end else begin
      desc_irq <= (state == ST_WBACK) && mp_done && ctrl_word[DSC_IRQ];
      broadcast_out <= (state == ST_WBACK) && mp_done && !is_m2m;
      busy <= (state != ST_IDLE);
    end
  end

  dmd_mem_port u_mem_port (
    .clock(clock),
    .nrst(nrst),
    .cmd_go(mp_go),
    .cmd_we(mp_we),
    .cmd_addr(mp_addr),
    .cmd_wdata(mp_wdata),
    .busy(mp_busy),
    .done(mp_done),
    .rdata(mp_rdata),
    .mem(mem),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  dmd_byte_count u_count (
    .clock(clock),
    .nrst(nrst),
    .load(cnt_load),
    .load_count(ctrl_word[31:DSC_CNT_LO]),
    .beat(xfer_beat && state == ST_RUN),
    .size(size),
    .left(cnt_left),
    .moved_m1(cnt_moved_m1),
    .terminal(cnt_terminal)
  );
endmodule // dmd_decoder
`default_nettype wire

/* File: dmd_properties.sv */
// assertion checker for the descriptor decoder ports
`timescale 1ns/1ps
`default_nettype none
module dmd_properties
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // observed ports
  input wire dmd_mem_s mem,
  input wire logic mem_ack,
  input wire logic xfer_start,
  input wire dmd_xfer_s xfer_info,
  input wire logic crc_clear,
  input wire logic broadcast_out,
  input wire logic desc_irq,
  input wire logic busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  mem_hold_a: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
    else $error("memory request moved before ack");
  mem_drop_a: assert property (mem.req && mem_ack |=> !mem.req)
    else $error("memory request held after ack");
  wb_place_a: assert property (mem.req && mem.we |-> mem.addr[2:0] == 3'h4)
    else $error("write-back off the control word");
  wb_empty_a: assert property (mem.req && mem.we && xfer_info.dir == DIR_M2D
    |-> !mem.wdata[DSC_BUF])
    else $error("buffer not marked empty");
  wb_full_a: assert property (mem.req && mem.we && xfer_info.dir == DIR_D2M
    |-> mem.wdata[DSC_BUF])
    else $error("buffer not marked full");
  crc_pair_a: assert property (crc_clear |-> xfer_start && busy)
    else $error("crc clear outside a start");
  info_hold_a: assert property (xfer_start |=> $stable(xfer_info) [*3])
    else $error("transfer info changed in run");
  irq_after_a: assert property (desc_irq |-> $past(mem_ack, 2) && $past(mem.we, 2))
    else $error("descriptor irq without write-back");
  bcast_dev_a: assert property (broadcast_out |-> $past(mem_ack, 2) && xfer_info.dir != DIR_M2M)
    else $error("broadcast without device write-back");
endmodule // dmd_properties
bind dmd_decoder dmd_properties dmd_properties_i (.clock(clock), .nrst(nrst), .mem(mem),
  .mem_ack(mem_ack), .xfer_start(xfer_start), .xfer_info(xfer_info), .crc_clear(crc_clear),
  .broadcast_out(broadcast_out), .desc_irq(desc_irq), .busy(busy));
`default_nettype wire

/* File: dmd_mem_model.sv */
// system memory model holding the descriptor table
`timescale 1ns/1ps
`default_nettype none
module dmd_mem_model
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // memory port
  input wire dmd_mem_s mem,
  input wire logic [3:0] delay,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [0:255];
  logic [3:0] waited;
  always @(posedge clock) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      waited <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem.req && !mem_ack && waited >= delay) begin
      mem_ack <= 1'b1;
      waited <= 4'h0;
      if (mem.we) ram[mem.addr[9:2]] <= mem.wdata;
      mem_rdata <= mem.we ? ~mem_rdata : ram[mem.addr[9:2]];
    end else begin
      mem_ack <= 1'b0;
      waited <= mem.req ? waited + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // dmd_mem_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the descriptor decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dmd_pkg::*;
;
  typedef struct packed {dmd_xfer_s x; logic crc;} dmd_exp_s;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic dev_req = 1'b0;
  logic xfer_beat = 1'b0;
  logic xfer_last = 1'b0;
  logic broadcast_in = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [31:0] reg_rdata, mem_rdata;
  logic mem_ack, xfer_start, crc_clear, broadcast_out, desc_irq, busy;
  dmd_mem_s mem;
  dmd_xfer_s xfer_info;
  int errors = 0;
  int checks_done = 0;
  int irqs = 0;
  int bcasts = 0;
  logic rd_d = 1'b0;
  logic [31:0] rd_q[$];
  logic [63:0] wb_q[$];
  dmd_exp_s st_q[$];
  always #2.5 clock = ~clock;
  dmd_decoder dmd_decoder_i (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dev_req(dev_req),
    .xfer_beat(xfer_beat), .xfer_last(xfer_last), .xfer_start(xfer_start),
    .xfer_info(xfer_info), .crc_clear(crc_clear), .broadcast_in(broadcast_in),
    .broadcast_out(broadcast_out), .desc_irq(desc_irq), .busy(busy));
  dmd_mem_model dmd_mem_model_i (.clock(clock), .nrst(nrst), .mem(mem), .delay(delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] ctl(input logic [15:0] c, input logic b,
    input logic [2:0] f, input logic [1:0] a);
    return {c, 10'($urandom()), b, f, a};
  endfunction
  function automatic logic [31:0] wbv(input logic [31:0] w, input logic [15:0] m, input logic b);
    return {m, w[15:6], b, w[4:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  task automatic request();
    @(posedge clock);
    dev_req <= 1'b1;
    @(posedge clock);
    dev_req <= 1'b0;
  endtask
  // waits for a start, moves n items, optionally ends early, waits for write-back
  task automatic run(input int n, input logic last);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clock);
      if (xfer_start === 1'b1) break;
    end
    chk(64'(k < 300), 64'h1);
    repeat (n) begin
      @(posedge clock);
      xfer_beat <= 1'b1;
      @(posedge clock);
      xfer_beat <= 1'b0;
    end
    if (last) begin
      @(posedge clock);
      xfer_last <= 1'b1;
      @(posedge clock);
      xfer_last <= 1'b0;
    end
    for (k = 0; k < 300; k++) begin
      @(posedge clock);
      if (mem.req && mem.we && mem_ack) break;
    end
    chk(64'(k < 300), 64'h1);
  endtask
  always @(posedge clock) begin : mon
    dmd_exp_s e;
    if (rd_d) chk(64'(reg_rdata), 64'(rd_q.pop_front()));
    rd_d = reg_read && nrst;
    if (nrst && xfer_start === 1'b1) begin
      if (st_q.size() == 0) chk(64'h1, 64'h0);
      else begin
        e = st_q.pop_front();
        chk(64'({xfer_info.dst, xfer_info.count, xfer_info.dir, xfer_info.size}),
          64'({e.x.dst, e.x.count, e.x.dir, e.x.size}));
        chk(64'(crc_clear), 64'(e.crc));
        if (e.x.dir == DIR_M2M) chk(64'(xfer_info.src), 64'(e.x.src));
      end
    end
    if (nrst && mem.req && mem.we && mem_ack) chk({mem.addr, mem.wdata}, wb_q.pop_front());
    if (nrst && desc_irq) irqs++;
    if (nrst && broadcast_out) bcasts++;
  end
  initial begin
    logic [31:0] a0, a1, w0, w1;
    void'($urandom(32'h9a29e8b4));
    tick(8);
    nrst <= 1'b1;
    // two device entries, the first continuous, the second cut short
    a0 = $urandom();
    a1 = $urandom();
    w0 = ctl(16'h0007, 1'b1, 3'b101, ACT_NEXT);
    w1 = ctl(16'h000b, 1'b1, 3'b010, ACT_HALT);
    dmd_mem_model_i.ram[8'h40] = a0;
    dmd_mem_model_i.ram[8'h41] = w0;
    dmd_mem_model_i.ram[8'h42] = a1;
    dmd_mem_model_i.ram[8'h43] = w1;
    delay <= 4'($urandom() % 6);
    reg_wr(OFS_TABLE_BASE, 32'h100);
    reg_wr(OFS_CONTROL, 32'h23);
    reg_rd(OFS_TABLE_BASE, 32'h100);
    reg_rd(5'h1c, 32'h0);
    reg_rd(OFS_CONTROL, 32'h22);
    tick(40);
    chk(64'(busy), 64'h1);
    st_q.push_back('{'{32'h0, a0, 16'h0007, DIR_M2D, SZ_32}, 1'b1});
    st_q.push_back('{'{32'h0, a1, 16'h000b, DIR_M2D, SZ_32}, 1'b0});
    wb_q.push_back({32'h104, wbv(w0, 16'h0007, 1'b0)});
    wb_q.push_back({32'h10c, wbv(w1, 16'h0003, 1'b0)});
    request();
    run(2, 1'b0);
    run(1, 1'b1);
    tick(20);
    chk(64'(busy), 64'h0);
    reg_rd(OFS_REMAIN, 32'h8);
    chk(64'(irqs), 64'h1);
    chk(64'(bcasts), 64'h2);
    // device-to-memory entry that first finds the buffer full
    w0 = ctl(16'h0001, 1'b1, 3'b000, ACT_RESTART);
    dmd_mem_model_i.ram[8'h60] = a0;
    dmd_mem_model_i.ram[8'h61] = w0;
    delay <= 4'($urandom() % 6);
    reg_wr(OFS_TABLE_BASE, 32'h180);
    reg_wr(OFS_CONTROL, 32'h1b);
    request();
    tick(40);
    w1 = w0 & 32'hffff_ffdf;
    dmd_mem_model_i.ram[8'h60] = a1;
    dmd_mem_model_i.ram[8'h61] = w1;
    st_q.push_back('{'{32'h0, a1, 16'h0001, DIR_D2M, SZ_16}, 1'b1});
    wb_q.push_back({32'h184, wbv(w1, 16'h0001, 1'b1)});
    @(posedge clock);
    broadcast_in <= 1'b1;
    @(posedge clock);
    broadcast_in <= 1'b0;
    request();
    run(1, 1'b0);
    tick(40);
    reg_rd(OFS_CUR_DESC, 32'h180);
    chk(64'(bcasts), 64'h3);
    @(posedge clock);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    reg_rd(OFS_STATUS, 32'h0);
    // memory-to-memory entry repeated, each pass on its own request
    a0 = $urandom();
    a1 = $urandom();
    w0 = ctl(16'h0003, 1'b1, 3'b011, ACT_REPEAT);
    dmd_mem_model_i.ram[8'h80] = a0;
    dmd_mem_model_i.ram[8'h81] = $urandom();
    dmd_mem_model_i.ram[8'h82] = a1;
    dmd_mem_model_i.ram[8'h83] = w0;
    reg_wr(OFS_TABLE_BASE, 32'h200);
    reg_wr(OFS_CONTROL, 32'h07);
    repeat (2) begin
      st_q.push_back('{'{a0, a1, 16'h0003, DIR_M2M, SZ_8}, 1'b0});
      wb_q.push_back({32'h20c, wbv(w0, 16'h0003, 1'b1)});
      request();
      run(4, 1'b0);
      tick(30);
    end
    chk(64'(irqs), 64'h3);
    chk(64'(bcasts), 64'h3);
    chk(64'(st_q.size() + wb_q.size()), 64'h0);
    final_report();
  end
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
